/* File: rtl/ile_unit.v */
`timescale 1ns/1ps
`default_nettype none
`include "ile_consts.vh"
// What this block does
// - own latch per source, three addresses
// - request sets latch, enabled one asks
// - acceptance clears that source's latch
// - reset zeroes all pending latches
// - writing zero clears one latch
// - writing one never sets latch
// - pending latches readable by software
// - non-maskable accepted ignoring enables
// - enable flags at three addresses, RW
// - master zero blocks all maskable
// - maskable needs master and own flag
// - acceptance saves then clears master
// - return reloads master from stack
// - master enable is enable_low bit 0
// - enable instr sets, disable clears
// - reset clears master enable
// - source flag one allows, zero blocks
// - reset clears all source enables
// - fixed priority, non-maskable first
module ile_unit (
   input wire clk_sys,
   input wire nrst,
   // register port from the core, same clock
   input wire sfr_wr,
   input wire sfr_rd,
   input wire [7:0] sfr_addr,
   input wire [7:0] sfr_wdata,
   output reg [7:0] sfr_rdata_q,
   output reg sfr_hit_q,
   // source requests, one-cycle pulses from on-chip logic
   input wire [23:0] src_req,
   // core instruction events
   input wire enable_interrupts_instr,
   input wire disable_interrupts_instr,
   input wire return_instr,
   input wire saved_master_enable,
   // acceptance handshake
   input wire accept,
   output reg irq_q,
   output reg [4:0] irq_index_q,
   output reg irq_nonmaskable_q,
   output reg master_enable_flag_q,
   output reg stack_master_enable_q
);
   reg [23:0] pending_latch_q;
   reg [23:0] pending_latch_d;
   reg [23:0] enable_register_q;
   reg [23:0] enable_register_d;
   reg master_enable_flag_d;
   reg stack_master_enable_d;
   reg irq_d;
   reg [4:0] irq_index_d;
   reg irq_nonmaskable_d;
   reg [7:0] sfr_rdata_d;
   reg sfr_hit_d;
   wire [23:0] cand;
   wire found;
   wire [4:0] index;
   wire [23:0] nmi_pend;
   wire [23:0] mask_pend;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // lane map: low lane is bits 7:0, mid 15:8, high 23:16; the enable and
   // pending registers share the layout, only the addresses differ
   // bits 1:0 hold no latch and no enable; bit 0 of the low enable
   // address is the master flag instead
   // map an address to the byte lane of a 24-bit flag vector, 3 = none
   function [1:0] lane_of;
      input [7:0] addr;
      input is_pending;
      begin
         if (is_pending && addr == `ILE_ADDR_PENDING_LOW) begin
            lane_of = 2'h0;
         end else if (is_pending && addr == `ILE_ADDR_PENDING_MID) begin
            lane_of = 2'h1;
         end else if (is_pending && addr == `ILE_ADDR_PENDING_HIGH) begin
            lane_of = 2'h2;
         end else if (!is_pending && addr == `ILE_ADDR_ENABLE_LOW) begin
            lane_of = 2'h0;
         end else if (!is_pending && addr == `ILE_ADDR_ENABLE_MID) begin
            lane_of = 2'h1;
         end else if (!is_pending && addr == `ILE_ADDR_ENABLE_HIGH) begin
            lane_of = 2'h2;
         end else begin
            lane_of = 2'h3;
         end
      end
   endfunction

   // pick one byte out of a 24-bit vector
   function [7:0] byte_of;
      input [23:0] v;
      input [1:0] lane;
      begin
         if (lane == 2'h0) begin
            byte_of = v[7:0];
         end else if (lane == 2'h1) begin
            byte_of = v[15:8];
         end else if (lane == 2'h2) begin
            byte_of = v[23:16];
         end else begin
            byte_of = 8'h00;
         end
      end
   endfunction

   // spread a written byte over the lane it lands in, ones elsewhere
   function [23:0] spread;
      input [7:0] d;
      input [1:0] lane;
      begin
         if (lane == 2'h0) begin
            spread = {16'hFFFF, d};
         end else if (lane == 2'h1) begin
            spread = {8'hFF, d, 8'hFF};
         end else if (lane == 2'h2) begin
            spread = {d, 16'hFFFF};
         end else begin
            spread = 24'hFFFFFF;
         end
      end
   endfunction

   // replace one lane of a 24-bit vector by a written byte, keep the rest
   function [23:0] merge_lane;
      input [23:0] old;
      input [7:0] d;
      input [1:0] lane;
      begin
         merge_lane = (old & spread(8'h00, lane)) | (~spread(8'h00, lane) & {3{d}});
      end
   endfunction

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   // decoded once and shared by the write and the read paths
   wire [1:0] pend_lane;
   wire [1:0] en_lane;
   wire taken;
   assign pend_lane = lane_of(sfr_addr, 1'b1);
   assign en_lane = lane_of(sfr_addr, 1'b0);
   // an accept only counts while an offer stands
   assign taken = accept && irq_q;

   // ---------------------------------------------------------------
   // acceptance candidates
   // ---------------------------------------------------------------
   // non-maskable ignore enables
   assign nmi_pend = pending_latch_q & `ILE_NMI_MASK;
   assign mask_pend = master_enable_flag_q ?
      (pending_latch_q & enable_register_q & ~`ILE_NMI_MASK) : 24'h000000;
   assign cand = (nmi_pend != 24'h000000) ? nmi_pend : mask_pend;

   // lowest index wins among the candidates handed over
   ile_prio u_prio (
      .cand(cand),
      .found(found),
      .index(index)
   );

   // ---------------------------------------------------------------
   // pending latches
   // ---------------------------------------------------------------
   // plain load writes only clear; a request in the same cycle wins,
   // so a read-modify-write race is software's problem, not ours
   always @* begin
      pending_latch_d = pending_latch_q;
      // order matters: clears first, the request set comes last
      // write clears only
      if (sfr_wr && pend_lane != 2'h3) begin
         pending_latch_d = pending_latch_d & spread(sfr_wdata, pend_lane);
      end
      if (accept && irq_q) begin
         pending_latch_d[irq_index_q] = 1'b0;
      end
      pending_latch_d = pending_latch_d | src_req;
      // no latch for bits 0 and 1
      pending_latch_d = pending_latch_d & `ILE_LATCH_MASK;
   end

   // ---------------------------------------------------------------
   // enable register
   // ---------------------------------------------------------------
   // flags read/write at three addresses
   // the other two lanes keep their value, so a byte write never
   // disturbs flags that software did not address
   always @* begin
      enable_register_d = enable_register_q;
      if (sfr_wr && en_lane != 2'h3) begin
         enable_register_d = merge_lane(enable_register_q, sfr_wdata, en_lane);
         enable_register_d = enable_register_d & `ILE_LATCH_MASK;
      end
   end

   // ---------------------------------------------------------------
   // master enable flag
   // ---------------------------------------------------------------
   // later ifs win: write, then instructions, then acceptance last
   always @* begin
      master_enable_flag_d = master_enable_flag_q;
      // master in low lane bit 0
      if (sfr_wr && en_lane == 2'h0) begin
         master_enable_flag_d = sfr_wdata[`ILE_BIT_MASTER];
      end
      if (enable_interrupts_instr) begin
         master_enable_flag_d = 1'b1;
      end
      if (disable_interrupts_instr) begin
         master_enable_flag_d = 1'b0;
      end
      if (return_instr) begin
         master_enable_flag_d = saved_master_enable;
      end
      if (accept && irq_q) begin
         master_enable_flag_d = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // state registers
   // ---------------------------------------------------------------
   // all pending latches zero on reset
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pending_latch_q <= `ILE_RST_PENDING;
      end else begin
         pending_latch_q <= pending_latch_d;
      end
   end

   // all source enables zero on reset
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         enable_register_q <= `ILE_RST_ENABLE;
      end else begin
         enable_register_q <= enable_register_d;
      end
   end

   // master flag and its pushed copy zero on reset
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         master_enable_flag_q <= 1'b0;
         stack_master_enable_q <= 1'b0;
      end else begin
         master_enable_flag_q <= master_enable_flag_d;
         stack_master_enable_q <= stack_master_enable_d;
      end
   end

   // save master before clearing
   // the core pushes this copy; it stands until the next acceptance
   always @* begin
      stack_master_enable_d = stack_master_enable_q;
      if (taken) begin
         stack_master_enable_d = master_enable_flag_q;
      end
   end

   // ---------------------------------------------------------------
   // request to the core
   // ---------------------------------------------------------------
   // registered so the core sees a stable index; costs one cycle
   // limitation: a latch cleared by software still shows for one
   // cycle, so the core should accept only at instruction boundaries
   always @* begin
      irq_d = found;
      irq_index_d = index;
      irq_nonmaskable_d = found && (nmi_pend != 24'h000000);
      // drop for one cycle so the cleared latch is not re-offered
      if (taken) begin
         irq_d = 1'b0;
         irq_index_d = irq_index_q;
         irq_nonmaskable_d = irq_nonmaskable_q;
      end
   end

   // offer registers; index and kind follow the scan, and hold while an accepted offer drops
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         irq_q <= 1'b0;
         irq_index_q <= 5'h00;
         irq_nonmaskable_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
         irq_index_q <= irq_index_d;
         irq_nonmaskable_q <= irq_nonmaskable_d;
      end
   end

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   // latches and flags readable
   // data is zero outside a read so a shared read bus can OR lanes
   always @* begin
      sfr_rdata_d = 8'h00;
      sfr_hit_d = 1'b0;
      if (sfr_rd && pend_lane != 2'h3) begin
         sfr_rdata_d = byte_of(pending_latch_q, pend_lane);
         sfr_hit_d = 1'b1;
      end else if (sfr_rd && en_lane == 2'h0) begin
         sfr_rdata_d = {enable_register_q[7:1], master_enable_flag_q};
         sfr_hit_d = 1'b1;
      end else if (sfr_rd && en_lane != 2'h3) begin
         sfr_rdata_d = byte_of(enable_register_q, en_lane);
         sfr_hit_d = 1'b1;
      end
   end

   // read data registers
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sfr_rdata_q <= 8'h00;
         sfr_hit_q <= 1'b0;
      end else begin
         sfr_rdata_q <= sfr_rdata_d;
         sfr_hit_q <= sfr_hit_d;
      end
   end
endmodule
`default_nettype wire

/* File: inc/ile_consts.vh */
`ifndef ILE_CONSTS_VH
`define ILE_CONSTS_VH
// ---------------------------------------------------------------
// special-function addresses
// ---------------------------------------------------------------
`define ILE_ADDR_ENABLE_HIGH 8'h2C
`define ILE_ADDR_ENABLE_LOW 8'h3A
`define ILE_ADDR_ENABLE_MID 8'h3B
`define ILE_ADDR_PENDING_HIGH 8'h2E
`define ILE_ADDR_PENDING_LOW 8'h3C
`define ILE_ADDR_PENDING_MID 8'h3D
// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define ILE_BIT_MASTER 0
`define ILE_BIT_TRAP 2
`define ILE_BIT_WDOG 3
`define ILE_FIRST_MASKABLE 4
`define ILE_NSRC 24
`define ILE_RST_ENABLE 24'h000000
`define ILE_RST_PENDING 24'h000000
`define ILE_NMI_MASK 24'h00000C
`define ILE_LATCH_MASK 24'hFFFFFC
`endif

/* File: rtl/ile_prio.v */
`timescale 1ns/1ps
`default_nettype none
`include "ile_consts.vh"
// lowest index wins; caller gives only acceptable candidates
module ile_prio (
   input wire [23:0] cand,
   output reg found,
   output reg [4:0] index
);
   integer i;
   // ---------------------------------------------------------------
   // fixed priority scan
   // ---------------------------------------------------------------
   // scan downward so the lowest set index is the one left standing
   always @* begin
      found = 1'b0;
      index = 5'h00;
      for (i = `ILE_NSRC - 1; i >= 0; i = i - 1) begin
         if (cand[i]) begin
            found = 1'b1;
            index = i[4:0];
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb/ile_unit_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module ile_unit_sva (
   input wire clk_sys,
   input wire nrst,
   input wire sfr_wr,
   input wire sfr_rd,
   input wire [7:0] sfr_addr,
   input wire [7:0] sfr_rdata_q,
   input wire sfr_hit_q,
   input wire enable_interrupts_instr,
   input wire disable_interrupts_instr,
   input wire return_instr,
   input wire saved_master_enable,
   input wire accept,
   input wire irq_q,
   input wire [4:0] irq_index_q,
   input wire irq_nonmaskable_q,
   input wire master_enable_flag_q,
   input wire stack_master_enable_q
);
   // acceptance and write collisions also change the master flag
   wire acc_w = accept && irq_q;
   wire quiet_w = !sfr_wr && !acc_w;
   wire map_w = sfr_addr inside {8'h2C, 8'h2E, 8'h3A, 8'h3B, 8'h3C, 8'h3D};
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   rd_idle_a: assert property (
      !sfr_rd |=> !sfr_hit_q && sfr_rdata_q == 8'h00) else $error("read data outside read");
   rd_hit_a: assert property (
      sfr_rd |=> sfr_hit_q == $past(map_w) && ($past(map_w) || sfr_rdata_q == 8'h00))
      else $error("hit flag wrong");
   acc_clr_a: assert property (
      acc_w |=> !irq_q && !master_enable_flag_q) else $error("accept did not mask");
   stack_save_a: assert property (
      acc_w |=> stack_master_enable_q == $past(master_enable_flag_q)) else $error("stack value");
   ei_set_a: assert property (
      enable_interrupts_instr && !disable_interrupts_instr && !return_instr && quiet_w
      |=> master_enable_flag_q) else $error("enable instr ignored");
   di_clr_a: assert property (
      disable_interrupts_instr && !return_instr && quiet_w |=> !master_enable_flag_q)
      else $error("disable instr ignored");
   ret_load_a: assert property (
      return_instr && quiet_w |=> master_enable_flag_q == $past(saved_master_enable))
      else $error("return reload wrong");
   mask_gate_a: assert property (
      irq_q && !irq_nonmaskable_q |-> $past(master_enable_flag_q)) else $error("masked offer");
   nmi_kind_a: assert property (
      irq_q |-> irq_index_q >= 5'h02 && irq_nonmaskable_q == (irq_index_q < 5'h04))
      else $error("offer index kind");
   cover property (acc_w && irq_nonmaskable_q);
   cover property (acc_w && irq_index_q == 5'h09);
   cover property (return_instr && saved_master_enable);
endmodule
bind ile_unit ile_unit_sva u_ile_unit_sva (.clk_sys, .nrst, .sfr_wr, .sfr_rd, .sfr_addr,
   .sfr_rdata_q, .sfr_hit_q, .enable_interrupts_instr, .disable_interrupts_instr,
   .return_instr, .saved_master_enable, .accept, .irq_q, .irq_index_q, .irq_nonmaskable_q,
   .master_enable_flag_q, .stack_master_enable_q);
`default_nettype wire

/* File: tb/ile_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// core side: accepts offers, keeps the pushed master value
// ------------------------------------------------------------
module ile_core_model (
   input wire clk_sys,
   input wire nrst,
   input wire irq_q,
   input wire stack_master_enable_q,
   input wire hold,
   output var logic accept,
   output var logic saved_master_enable
);
   logic pushed_q;
   // hold stalls the core so offers must stand
   // push then pop master
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         accept <= 1'b0;
         pushed_q <= 1'b0;
         saved_master_enable <= 1'b0;
      end else begin
         accept <= irq_q && !accept && !hold;
         pushed_q <= accept && irq_q;
         if (pushed_q) begin
            saved_master_enable <= stack_master_enable_q;
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb/ile_unit_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// bench
// ------------------------------------------------------------
module ile_unit_tb_top;
   logic clk_sys, nrst, sfr_wr, sfr_rd, hold, ei_s, di_s, ret_s;
   logic [7:0] sfr_addr, sfr_wdata;
   logic [23:0] src_req;
   wire [7:0] rdata;
   wire [4:0] idx;
   wire hit, irq, nmi, mef, smef, accept, saved;
   int err_total, n_tests;
   logic [7:0] map_a [6] = '{8'h3A, 8'h3B, 8'h2C, 8'h3C, 8'h3D, 8'h2E};
   ile_unit u_ile_unit (.clk_sys(clk_sys), .nrst(nrst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata_q(rdata), .sfr_hit_q(hit),
      .src_req(src_req), .enable_interrupts_instr(ei_s), .disable_interrupts_instr(di_s),
      .return_instr(ret_s), .saved_master_enable(saved), .accept(accept), .irq_q(irq),
      .irq_index_q(idx), .irq_nonmaskable_q(nmi), .master_enable_flag_q(mef),
      .stack_master_enable_q(smef));
   ile_core_model u_ile_core_model (.clk_sys(clk_sys), .nrst(nrst), .irq_q(irq),
      .stack_master_enable_q(smef), .hold(hold), .accept(accept), .saved_master_enable(saved));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task chk(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      sfr_wr = 1'b1;
      sfr_addr = a;
      sfr_wdata = d;
      @(negedge clk_sys);
      sfr_wr = 1'b0;
   endtask
   // expectation is {hit, data}
   task rd(input logic [7:0] a, input logic [8:0] e);
      @(negedge clk_sys);
      sfr_rd = 1'b1;
      sfr_addr = a;
      @(negedge clk_sys);
      sfr_rd = 1'b0;
      chk({hit, rdata}, e);
   endtask
   task instr(input logic [2:0] v);
      @(negedge clk_sys);
      {ei_s, di_s, ret_s} = v;
      @(negedge clk_sys);
      {ei_s, di_s, ret_s} = 3'h0;
   endtask
   // request pulse, then two edges for the offer to show
   task pulse(input logic [23:0] v);
      @(negedge clk_sys);
      src_req = v;
      @(negedge clk_sys);
      src_req = 24'h000000;
      repeat (2) @(negedge clk_sys);
   endtask
   task wait_acc(input logic [4:0] e);
      hold = 1'b0;
      for (int i = 0; i < 20 && !(accept && irq); i++) @(negedge clk_sys);
      chk({irq, nmi, idx}, {1'b1, e < 5'h04, e});
      hold = 1'b1;
      @(negedge clk_sys);
      chk({irq, mef}, 2'h0);
   endtask
   task t_reset;
      foreach (map_a[i]) rd(map_a[i], 9'h100);
      rd(8'h40, 9'h000);
      $display("test reset done");
   endtask
   task t_enable;
      wr(8'h3A, 8'hF2);
      rd(8'h3A, 9'h1F0);
      instr(3'h4);
      rd(8'h3A, 9'h1F1);
      instr(3'h2);
      rd(8'h3A, 9'h1F0);
      wr(8'h3B, 8'hA5);
      rd(8'h3B, 9'h1A5);
      wr(8'h2C, 8'h5A);
      rd(8'h2C, 9'h15A);
      $display("test enable done");
   endtask
   task t_pending;
      pulse(24'hFFFFF3);
      chk(irq, 1'b0);
      rd(8'h3C, 9'h1F0);
      rd(8'h3D, 9'h1FF);
      rd(8'h2E, 9'h1FF);
      wr(8'h3D, 8'h0F);
      rd(8'h3D, 9'h10F);
      wr(8'h3D, 8'hFF);
      rd(8'h3D, 9'h10F);
      wr(8'h3C, 8'h0C);
      wr(8'h3D, 8'h00);
      wr(8'h2E, 8'h00);
      pulse(24'h000008);
      wait_acc(5'h03);
      rd(8'h3C, 9'h100);
      $display("test pending done");
   endtask
   task t_prio;
      wr(8'h3A, 8'h40);
      wr(8'h3B, 8'h02);
      pulse(24'h000260);
      chk(irq, 1'b0);
      instr(3'h4);
      wait_acc(5'h06);
      chk(smef, 1'b1);
      instr(3'h1);
      wait_acc(5'h09);
      rd(8'h3C, 9'h120);
      rd(8'h3D, 9'h100);
      $display("test priority done");
   endtask
   // reset in mid run clears latches, enables and master
   task t_midreset;
      wr(8'h3A, 8'h10);
      instr(3'h4);
      pulse(24'h000010);
      chk({irq, idx}, {1'b1, 5'h04});
      nrst = 1'b0;
      repeat (2) @(negedge clk_sys);
      nrst = 1'b1;
      chk({irq, mef}, 2'h0);
      foreach (map_a[i]) rd(map_a[i], 9'h100);
      instr(3'h4);
      pulse(24'h000010);
      chk({irq, mef}, 2'h1);
      $display("test midreset done");
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      {nrst, sfr_wr, sfr_rd, ei_s, di_s, ret_s} = 6'h00;
      {sfr_addr, sfr_wdata, src_req} = 40'h0;
      hold = 1'b1;
      repeat (16) @(negedge clk_sys);
      nrst = 1'b1;
      t_reset;
      t_enable;
      t_pending;
      t_prio;
      t_midreset;
      print_verdict;
   end
   // well under two hundred cycles are expected
   initial begin
      #(50 * 20000);
      err_total++;
      print_verdict;
   end
endmodule
`default_nettype wire
